// ==== rpes_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module rpes_host_model (
    input  wire logic core_clk,
    output var  logic wlan_power_enable,
    output var  logic bluetooth_power_enable
);
    // Both enables go low together, as while the device is held in reset.
    task automatic release_all();
        bluetooth_power_enable = 1'b0;
        wlan_power_enable      = 1'b0;
    endtask

    // Bluetooth moves first, then WLAN after a lead of whole cycles.
    task automatic drive(input logic wl, input logic bt, input int lead);
        @(negedge core_clk);
        bluetooth_power_enable = bt;
        repeat (lead) @(negedge core_clk);
        wlan_power_enable = wl;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
endmodule // rpes_host_model
`default_nettype wire

// ==== rpes_pkg.sv ====
`default_nettype none
package rpes_pkg;

    // Control clock rate and the documented waits.
    localparam int unsigned CLK_HZ          = 125_000_000;
    localparam int unsigned DISCHARGE_MS    = 10;
    localparam int unsigned POR_RELEASE_MS  = 110;
    localparam int unsigned HOST_ACCESS_MS  = 150;
    localparam int unsigned BT_HOLD_MS      = 100;
    localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
    localparam int unsigned DISCHARGE_CYC   = DISCHARGE_MS * CYC_PER_MS;
    localparam int unsigned POR_RELEASE_CYC = POR_RELEASE_MS * CYC_PER_MS;
    localparam int unsigned HOST_ACCESS_CYC = HOST_ACCESS_MS * CYC_PER_MS;
    localparam int unsigned BT_HOLD_CYC     = BT_HOLD_MS * CYC_PER_MS;
    localparam int unsigned CNT_W           = 32;

    // Synchronised enable pair.
    typedef struct packed {
        logic wlan;
        logic bluetooth;
    } rpes_en_t;

    typedef enum logic [1:0] {
        RPES_OFF,
        RPES_POR_WAIT,
        RPES_RUN
    } rpes_state_t;

endpackage
`default_nettype wire

// ==== rpes_sequencer.sv ====
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - WLAN enable high: regulators on, WLAN released once the internal reset is released.
// - WLAN enable low: WLAN held in reset.
// - Regulators on when either enable high.
// - Bluetooth low, WLAN high: Bluetooth in reset.
// - Internal reset released within 110 ms.
module rpes_sequencer #(
    parameter int unsigned POR_RELEASE_CYC = rpes_pkg::POR_RELEASE_CYC,
    parameter int unsigned HOST_ACCESS_CYC = rpes_pkg::HOST_ACCESS_CYC,
    parameter int unsigned DISCHARGE_CYC   = rpes_pkg::DISCHARGE_CYC,
    parameter int unsigned BT_HOLD_CYC     = rpes_pkg::BT_HOLD_CYC
) (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic wlan_power_enable,
    input  wire logic bluetooth_power_enable,
    input  wire logic supplies_good,
    output var  logic regulator_enable,
    output var  logic wlan_reset_b,
    output var  logic bluetooth_reset_b,
    output var  logic core_reset_b,
    output var  logic host_access_ready,
    output var  logic discharge_violation,
    output var  logic bt_order_violation
);

    if (POR_RELEASE_CYC < 1)
    begin : gen_bad_por
        $error("rpes_sequencer: POR_RELEASE_CYC must be at least 1");
    end
    if (HOST_ACCESS_CYC <= POR_RELEASE_CYC)
    begin : gen_bad_host
        $error("rpes_sequencer: HOST_ACCESS_CYC must exceed POR_RELEASE_CYC");
    end
    if (DISCHARGE_CYC < 1)
    begin : gen_bad_discharge
        $error("rpes_sequencer: DISCHARGE_CYC must be at least 1");
    end
    if (BT_HOLD_CYC < 1)
    begin : gen_bad_hold
        $error("rpes_sequencer: BT_HOLD_CYC must be at least 1");
    end

    rpes_pkg::rpes_en_t    sync1_reg;
    rpes_pkg::rpes_en_t    sync2_reg;
    rpes_pkg::rpes_en_t    prev_reg;
    rpes_pkg::rpes_state_t state_reg;
    logic [rpes_pkg::CNT_W-1:0] por_cnt_reg;
    logic [rpes_pkg::CNT_W-1:0] off_cnt_reg;
    logic [rpes_pkg::CNT_W-1:0] wl_cnt_reg;
    logic                       any_en;

    // Two-stage synchroniser on both enables.
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg  <= '0;
        end
        else
        begin
            sync1_reg <= {wlan_power_enable, bluetooth_power_enable};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    assign any_en = sync2_reg.wlan | sync2_reg.bluetooth;

    // Section controls follow the synchronised enables.
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            regulator_enable  <= 1'b0;
            wlan_reset_b      <= 1'b0;
            bluetooth_reset_b <= 1'b0;
        end
        else
        begin
            regulator_enable  <= any_en;
            wlan_reset_b      <= sync2_reg.wlan && state_reg == rpes_pkg::RPES_RUN;
            bluetooth_reset_b <= sync2_reg.bluetooth && state_reg == rpes_pkg::RPES_RUN;
        end
    end

    // Power-on wait after supplies come up.
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg         <= rpes_pkg::RPES_OFF;
            por_cnt_reg       <= '0;
            core_reset_b      <= 1'b0;
            host_access_ready <= 1'b0;
        end
        else
        begin
            case (state_reg)
                rpes_pkg::RPES_OFF:
                begin
                    por_cnt_reg       <= '0;
                    core_reset_b      <= 1'b0;
                    host_access_ready <= 1'b0;
                    if (any_en && supplies_good)
                        state_reg <= rpes_pkg::RPES_POR_WAIT;
                end
                rpes_pkg::RPES_POR_WAIT:
                begin
                    por_cnt_reg <= por_cnt_reg + 1'b1;
                    if (!any_en || !supplies_good)
                        state_reg <= rpes_pkg::RPES_OFF;
                    else if (por_cnt_reg == rpes_pkg::CNT_W'(POR_RELEASE_CYC - 1))
                    begin
                        core_reset_b <= 1'b1;
                        state_reg    <= rpes_pkg::RPES_RUN;
                    end
                end
                rpes_pkg::RPES_RUN:
                begin
                    if (por_cnt_reg != rpes_pkg::CNT_W'(HOST_ACCESS_CYC))
                        por_cnt_reg <= por_cnt_reg + 1'b1;
                    else
                        host_access_ready <= 1'b1;
                    if (!any_en || !supplies_good)
                        state_reg <= rpes_pkg::RPES_OFF;
                end
                default:
                    state_reg <= rpes_pkg::RPES_OFF;
            endcase
        end
    end

    // Host-side sequencing monitors; flags stick until reset.
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            off_cnt_reg         <= rpes_pkg::CNT_W'(DISCHARGE_CYC);
            wl_cnt_reg          <= '0;
            discharge_violation <= 1'b0;
            bt_order_violation  <= 1'b0;
        end
        else
        begin
            if (any_en)
                off_cnt_reg <= '0;
            else if (off_cnt_reg != rpes_pkg::CNT_W'(DISCHARGE_CYC))
                off_cnt_reg <= off_cnt_reg + 1'b1;
            if (any_en && !(prev_reg.wlan | prev_reg.bluetooth) && off_cnt_reg != rpes_pkg::CNT_W'(DISCHARGE_CYC))
                discharge_violation <= 1'b1;
            if (!sync2_reg.wlan)
                wl_cnt_reg <= '0;
            else if (wl_cnt_reg != rpes_pkg::CNT_W'(BT_HOLD_CYC))
                wl_cnt_reg <= wl_cnt_reg + 1'b1;
            if (sync2_reg.wlan && !prev_reg.wlan && !sync2_reg.bluetooth)
                bt_order_violation <= 1'b1;
            if (sync2_reg.wlan && prev_reg.bluetooth && !sync2_reg.bluetooth
                && wl_cnt_reg != rpes_pkg::CNT_W'(BT_HOLD_CYC))
                bt_order_violation <= 1'b1;
        end
    end

    reg_follows_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        regulator_enable == $past(any_en))
        else $error("regulator enable does not follow either enable");
    wlan_rst_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !sync2_reg.wlan |=> !wlan_reset_b)
        else $error("WLAN released while enable low");
    wlan_run_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (sync2_reg.wlan && state_reg == rpes_pkg::RPES_RUN) |=> wlan_reset_b && regulator_enable)
        else $error("WLAN not released while enabled");
    bt_rst_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!sync2_reg.bluetooth && sync2_reg.wlan) |=> !bluetooth_reset_b)
        else $error("Bluetooth released while enable low");
    bt_run_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (sync2_reg.bluetooth && state_reg == rpes_pkg::RPES_RUN) |=> bluetooth_reset_b)
        else $error("Bluetooth not released while enabled");
    sync_delay_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(wlan_power_enable) ##1 wlan_power_enable |-> ##1 sync2_reg.wlan)
        else $error("enable not synchronised in two cycles");
    por_bound_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_reg == rpes_pkg::RPES_POR_WAIT |-> por_cnt_reg < rpes_pkg::CNT_W'(POR_RELEASE_CYC))
        else $error("internal reset held too long");
    supply_drop_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !supplies_good |-> ##2 !core_reset_b)
        else $error("internal reset not applied after supply loss");
    ready_after_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(host_access_ready) |-> core_reset_b && por_cnt_reg == rpes_pkg::CNT_W'(HOST_ACCESS_CYC))
        else $error("host access ready too early");
    ready_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        host_access_ready |-> core_reset_b)
        else $error("host access ready while internal reset held");
    order_flag_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (sync2_reg.wlan && !prev_reg.wlan && !sync2_reg.bluetooth) |=> bt_order_violation)
        else $error("order violation not flagged");
    bt_early_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (sync2_reg.wlan && prev_reg.bluetooth && !sync2_reg.bluetooth
            && wl_cnt_reg < rpes_pkg::CNT_W'(BT_HOLD_CYC)) |=> bt_order_violation)
        else $error("early Bluetooth drop not flagged");
    discharge_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $fell(any_en) ##1 any_en |=> discharge_violation)
        else $error("short off time not flagged");

    both_on_c: cover property (@(posedge core_clk) disable iff (!rst_b)
        wlan_reset_b && bluetooth_reset_b);
    wlan_only_c: cover property (@(posedge core_clk) disable iff (!rst_b)
        wlan_reset_b && !bluetooth_reset_b);
    ready_c: cover property (@(posedge core_clk) disable iff (!rst_b)
        $rose(host_access_ready));
    short_off_c: cover property (@(posedge core_clk) disable iff (!rst_b)
        $rose(discharge_violation));
    bad_order_c: cover property (@(posedge core_clk) disable iff (!rst_b)
        $rose(bt_order_violation));

endmodule // rpes_sequencer
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        core_clk = 1'b0;
    logic        rst_b;
    logic        supplies_good = 1'b1;
    logic        wl_en;
    logic        bt_en;
    logic        reg_on;
    logic        wl_rst_b;
    logic        bt_rst_b;
    logic        core_rst_b;
    logic        access_ok;
    logic        dis_flag;
    logic        ord_flag;
    logic [6:0]  outs;
    int          bad_count = 0;
    int          compares  = 0;
    int          cycles    = 0;
    logic [31:0] rnd       = 32'h0000_4559;

    always #4 core_clk = ~core_clk;

    rpes_host_model host (.core_clk(core_clk), .wlan_power_enable(wl_en), .bluetooth_power_enable(bt_en));

    rpes_sequencer #(.POR_RELEASE_CYC(20), .HOST_ACCESS_CYC(30), .DISCHARGE_CYC(10), .BT_HOLD_CYC(15)) uut (
        .core_clk(core_clk), .rst_b(rst_b), .wlan_power_enable(wl_en), .bluetooth_power_enable(bt_en),
        .supplies_good(supplies_good), .regulator_enable(reg_on), .wlan_reset_b(wl_rst_b),
        .bluetooth_reset_b(bt_rst_b), .core_reset_b(core_rst_b), .host_access_ready(access_ok),
        .discharge_violation(dis_flag), .bt_order_violation(ord_flag));

    assign outs = {reg_on, wl_rst_b, bt_rst_b, core_rst_b, access_ok, dis_flag, ord_flag};

    function automatic int next_rnd(int m);
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return int'(rnd % 32'(m));
    endfunction

    // Expected outputs from the host pins and the phase reached.
    function automatic logic [6:0] model(int core, int rdy, int dv, int bov);
        logic on;
        on = 1'(core);
        return {wl_en | bt_en, on & wl_en, on & bt_en, on, 1'(rdy), 1'(dv), 1'(bov)};
    endfunction

    task automatic check(input logic [6:0] seen, input logic [6:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic do_reset();
        rst_b = 1'b0;
        host.release_all();
        repeat (2) @(negedge core_clk);
        check(outs, 7'h00);
        rst_b = 1'b1;
    endtask

    task automatic close_out();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            bad_count++;
            close_out();
        end
    end

    initial
    begin
        do_reset();
        host.drive(1'b1, 1'b1, next_rnd(4));
        host.idle(8);
        check(outs, model(0, 0, 0, 0));
        host.idle(18);
        check(outs, model(1, 0, 0, 0));
        host.idle(14);
        check(outs, model(1, 1, 0, 0));
        host.idle(next_rnd(8));
        host.drive(1'b1, 1'b0, 0);
        host.idle(5);
        check(outs, model(1, 1, 0, 0));
        host.drive(1'b0, 1'b0, 0);
        host.idle(5);
        check(outs, model(0, 0, 0, 0));
        host.idle(3);
        host.drive(1'b1, 1'b1, 0);
        host.idle(5);
        check(outs, model(0, 0, 1, 0));
        do_reset();
        host.drive(1'b0, 1'b1, 0);
        host.idle(40);
        check(outs, model(1, 1, 0, 0));
        supplies_good = 1'b0;
        host.idle(3);
        check(outs, model(0, 0, 0, 0));
        supplies_good = 1'b1;
        host.idle(40);
        check(outs, model(1, 1, 0, 0));
        do_reset();
        host.drive(1'b1, 1'b1, 0);
        host.idle(4);
        host.drive(1'b1, 1'b0, 0);
        host.idle(5);
        check(outs, model(0, 0, 0, 1));
        do_reset();
        host.drive(1'b1, 1'b0, 0);
        host.idle(5);
        check(outs, model(0, 0, 0, 1));
        host.drive(1'b0, 1'b0, 0);
        host.drive(1'b1, 1'b0, 0);
        host.idle(5);
        check(outs, model(0, 0, 1, 1));
        close_out();
    end
endmodule // testbench
`default_nettype wire
